/* logic/pei_event_logic.sv */
// Protection, warning and fault event flags with interrupt line
module pei_event_logic #(
    parameter int SHORT_LIMIT = pei_pkg::SHORT_CYCLES
) (
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    input  wire logic [pei_pkg::NREG-1:0]   pg_in,
    input  wire logic [pei_pkg::NWARN-1:0]  warn_in,
    input  wire logic [pei_pkg::NREG-1:0]   prot_in,
    input  wire logic [pei_pkg::NFAULT-1:0] fault_in,
    input  wire logic [pei_pkg::NBUCK-1:0]  buck_low_in,
    input  wire logic [pei_pkg::NREG-1:0]   reg_en_req,
    input  wire logic [pei_pkg::NGPO-1:0]   gpo_req,
    input  wire logic [pei_pkg::NFLAG-1:0]  flag_mask,
    input  wire logic [pei_pkg::NFLAG-1:0]  flag_clr,
    input  wire logic                       reset_flag_clr,
    input  wire logic                       otp_reset_mask,
    input  wire logic                       soft_reset_trigger,
    output logic                            irq_line_n,
    output logic                            power_valid_output,
    output logic [pei_pkg::NREG-1:0]        reg_enable,
    output logic [pei_pkg::NGPO-1:0]        gpo_out,
    output logic [pei_pkg::NFLAG-1:0]       flags,
    output logic                            reset_flag,
    output logic                            reset_mask,
    output logic                            soft_reset_bit
);
    localparam int CW = $clog2(SHORT_LIMIT + 1);

    pei_pkg::pei_state_type           state;
    logic [pei_pkg::NSYNC-1:0]        sync_a;
    logic [pei_pkg::NSYNC-1:0]        sync_b;
    logic [pei_pkg::NREG-1:0]         pg_s;
    logic [pei_pkg::NREG-1:0]         pg_prev;
    logic [pei_pkg::NWARN-1:0]        warn_s;
    logic [pei_pkg::NREG-1:0]         prot_s;
    logic [pei_pkg::NFAULT-1:0]       fault_s;
    logic [pei_pkg::NBUCK-1:0]        low_s;
    logic [pei_pkg::NBUCK-1:0]        short_hit;
    logic [CW-1:0]                    short_cnt [pei_pkg::NBUCK];
    logic [pei_pkg::NFLAG-1:0]        set_vec;
    logic [pei_pkg::NREG-1:0]         blocked;
    logic                             running;
    logic                             cause_hold;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Comparator outputs are asynchronous to the oscillator clock
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {buck_low_in, fault_in, prot_in, warn_in, pg_in};
            sync_b <= sync_a;
        end
    end

    assign pg_s    = sync_b[pei_pkg::NREG-1:0];
    assign warn_s  = sync_b[pei_pkg::NREG +: pei_pkg::NWARN];
    assign prot_s  = sync_b[pei_pkg::NREG+pei_pkg::NWARN +: pei_pkg::NREG];
    assign fault_s = sync_b[2*pei_pkg::NREG+pei_pkg::NWARN +: pei_pkg::NFAULT];
    assign low_s   = sync_b[pei_pkg::NSYNC-1 -: pei_pkg::NBUCK];
    assign running = (state == pei_pkg::PEI_RUN);

    // ****************************************
    // Sequencer: run, shutdown, start-up
    // ****************************************
    // Soft reset acts on the trigger itself, not the registered bit; outputs drop two cycles after the trigger
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= pei_pkg::PEI_START;
        end else begin
            unique case (state)
                pei_pkg::PEI_RUN: begin
                    if ((|fault_s) || soft_reset_trigger) begin
                        state <= pei_pkg::PEI_SHUT;
                    end
                end
                pei_pkg::PEI_SHUT: begin
                    if (!(|fault_s)) begin
                        state <= pei_pkg::PEI_START;
                    end
                end
                pei_pkg::PEI_START: begin
                    state <= pei_pkg::PEI_RUN;
                end
                default: begin
                    state <= pei_pkg::PEI_SHUT;
                end
            endcase
        end
    end

    // Trigger bit reads back the trigger one cycle late and clears when the trigger drops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            soft_reset_bit <= 1'b0;
        end else begin
            soft_reset_bit <= soft_reset_trigger;
        end
    end

    // ****************************************
    // Buck short detection
    // ****************************************
    // Counter restarts whenever the output recovers above threshold
    for (genvar b = 0; b < pei_pkg::NBUCK; b++) begin : g_short
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                short_cnt[b] <= '0;
            end else if (!running || !reg_enable[b] || !low_s[b]) begin
                short_cnt[b] <= '0;
            end else if (short_cnt[b] != CW'(SHORT_LIMIT - 1)) begin
                short_cnt[b] <= short_cnt[b] + 1'b1;
            end
        end
        assign short_hit[b] = running && reg_enable[b] && low_s[b]
                              && (short_cnt[b] == CW'(SHORT_LIMIT - 1));
    end

    // ****************************************
    // Event flags
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pg_prev <= '0;
        end else begin
            pg_prev <= pg_s;
        end
    end

    always_comb begin
        set_vec = '0;
        set_vec[pei_pkg::PG_POS +: pei_pkg::NREG]     = pg_s & ~pg_prev & {pei_pkg::NREG{running}};
        set_vec[pei_pkg::WARN_POS +: pei_pkg::NWARN]  = warn_s & {pei_pkg::NWARN{running}};
        set_vec[pei_pkg::PROT_POS +: pei_pkg::NREG]   = prot_s & {pei_pkg::NREG{running}};
        set_vec[pei_pkg::SHORT_POS +: pei_pkg::NBUCK] = short_hit;
    end

    // Set beats a same-cycle clear; shutdown restores defaults
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flags <= pei_pkg::FLAGS_RST;
        end else if (state == pei_pkg::PEI_SHUT) begin
            flags <= pei_pkg::FLAGS_RST;
        end else begin
            flags <= set_vec | (flags & ~flag_clr);
        end
    end

    // ****************************************
    // Reset cause, kept across shutdown
    // ****************************************
    // Power-on or start-up clears the cause, so it survives shutdown until reset_flag samples it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cause_hold <= 1'b0;
        end else if (running && ((|fault_s) || soft_reset_trigger)) begin
            cause_hold <= 1'b1;
        end else if (state == pei_pkg::PEI_START) begin
            cause_hold <= 1'b0;
        end
    end

    // Mask has no host write path; reloaded from one-time bits at start-up
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reset_mask <= pei_pkg::RESET_MASK_RST;
        end else if (state == pei_pkg::PEI_START) begin
            reset_mask <= otp_reset_mask;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reset_flag <= 1'b0;
        end else if (state == pei_pkg::PEI_START && cause_hold && !otp_reset_mask) begin
            reset_flag <= 1'b1;
        end else if (reset_flag_clr) begin
            reset_flag <= 1'b0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // A pending protection or short flag keeps only its own regulator off
    always_comb begin
        blocked = flags[pei_pkg::PROT_POS +: pei_pkg::NREG];
        blocked[pei_pkg::NBUCK-1:0] = blocked[pei_pkg::NBUCK-1:0]
                                      | flags[pei_pkg::SHORT_POS +: pei_pkg::NBUCK];
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_enable <= '0;
            gpo_out    <= '0;
        end else begin
            reg_enable <= reg_en_req & ~blocked & {pei_pkg::NREG{running}};
            gpo_out    <= gpo_req & {pei_pkg::NGPO{running}};
        end
    end

    // Valid only while every requested rail reports good
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            power_valid_output <= 1'b0;
        end else begin
            power_valid_output <= running && (&(pg_s | ~reg_en_req));
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_line_n <= 1'b1;
        end else begin
            irq_line_n <= !((|(flags & ~flag_mask)) || reset_flag);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_pg_flag;
        $rose(pg_s[0]) && running |=> flags[pei_pkg::PG_POS];
    endproperty
    a_pg_flag: assert property (p_pg_flag) else $error("valid flag not set");

    property p_warn_only;
        warn_s[0] && running && !(|fault_s) && !soft_reset_trigger
            |=> flags[pei_pkg::WARN_POS] && running;
    endproperty
    a_warn_only: assert property (p_warn_only) else $error("warning misbehaved");

    property p_prot_off;
        prot_s[1] && running |=> ##1 !reg_enable[1];
    endproperty
    a_prot_off: assert property (p_prot_off) else $error("regulator stayed on");

    property p_fault_shut;
        fault_s[0] && running |=> state == pei_pkg::PEI_SHUT
            ##1 (reg_enable == '0 && gpo_out == '0);
    endproperty
    a_fault_shut: assert property (p_fault_shut) else $error("no shutdown on fault");
    property p_irq_low;
        (|(flags[pei_pkg::WARN_POS +: pei_pkg::NWARN + pei_pkg::NREG]
           & ~flag_mask[pei_pkg::WARN_POS +: pei_pkg::NWARN + pei_pkg::NREG])) |=> !irq_line_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("line not asserted");
    property p_irq_release;
        flags == '0 && !reset_flag |=> irq_line_n;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("line not released");

    property p_cause_flag;
        state == pei_pkg::PEI_START && $past(state) == pei_pkg::PEI_SHUT && !otp_reset_mask
            |=> reset_flag;
    endproperty
    a_cause_flag: assert property (p_cause_flag) else $error("cause flag missing");
    property p_cause_masked;
        state == pei_pkg::PEI_START && otp_reset_mask && !reset_flag |=> !reset_flag;
    endproperty
    a_cause_masked: assert property (p_cause_masked) else $error("masked cause raised");

    property p_soft_reset;
        soft_reset_trigger && running ##1 !soft_reset_trigger
            |=> !soft_reset_bit && reg_enable == '0 && gpo_out == '0 && flags == '0;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

    property p_short;
        short_hit[0] |=> flags[pei_pkg::SHORT_POS] ##1 !reg_enable[0];
    endproperty
    a_short: assert property (p_short) else $error("short not handled");

    property p_cause_hold;
        running && (|fault_s) |=> cause_hold;
    endproperty
    a_cause_hold: assert property (p_cause_hold) else $error("cause not held");

    c_fault_restart: cover property (state == pei_pkg::PEI_SHUT ##[1:20] running);
    c_soft_reset: cover property (running && soft_reset_trigger);
    c_short: cover property (short_hit[0]);
    c_irq: cover property ($fell(irq_line_n));
endmodule

/* logic/pei_pkg.sv */
// Constants and types shared by the protection event logic
package pei_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_HZ        = 100_000_000;
    localparam int SHORT_TIME_MS = 1;   // Short must persist this long
    localparam int SHORT_CYCLES  = SHORT_TIME_MS * (CLK_HZ / 1000);

    // ****************************************
    // Event counts and flag vector layout
    // ****************************************
    localparam int NREG      = 4;   // Two bucks then two linear regulators
    localparam int NBUCK     = 2;
    localparam int NWARN     = 2;
    localparam int NFAULT    = 2;
    localparam int NGPO      = 2;
    localparam int PG_POS    = 0;
    localparam int WARN_POS  = PG_POS + NREG;
    localparam int PROT_POS  = WARN_POS + NWARN;
    localparam int SHORT_POS = PROT_POS + NREG;
    localparam int NFLAG     = SHORT_POS + NBUCK;
    localparam int NSYNC     = NREG + NWARN + NREG + NFAULT + NBUCK;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [NFLAG-1:0] FLAGS_RST      = '0;
    localparam logic             RESET_MASK_RST = 1'b1;

    typedef enum logic [1:0] {
        PEI_RUN   = 2'b00,
        PEI_SHUT  = 2'b01,
        PEI_START = 2'b10
    } pei_state_type;
endpackage

/* verification/pei_event_logic_test.sv */
// Self-checking bench for the protection event logic
module pei_event_logic_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SL = 20; // Short filter shortened for simulation
    logic clk_sys = 1'b0, arst_n = 1'b0, serve = 1'b0, reset_flag_clr;
    logic [3:0] pg_in = '0, prot_in = '0, reg_en_req = 4'hF;
    logic [1:0] warn_in = '0, fault_in = '0, buck_low_in = '0, gpo_req = 2'h3;
    logic [11:0] flag_mask = '0, flag_clr, flags;
    logic otp_reset_mask = 1'b1, soft_reset_trigger = 1'b0;
    logic irq_line_n, power_valid_output, reset_flag, reset_mask, soft_reset_bit;
    logic [3:0] reg_enable;
    logic [1:0] gpo_out;
    int fail_count = 0, n_checks = 0;

    always #5 clk_sys = ~clk_sys;

    pei_event_logic #(.SHORT_LIMIT(SL)) pei_event_logic_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .pg_in(pg_in), .warn_in(warn_in),
        .prot_in(prot_in), .fault_in(fault_in), .buck_low_in(buck_low_in),
        .reg_en_req(reg_en_req), .gpo_req(gpo_req), .flag_mask(flag_mask),
        .flag_clr(flag_clr), .reset_flag_clr(reset_flag_clr),
        .otp_reset_mask(otp_reset_mask), .soft_reset_trigger(soft_reset_trigger),
        .irq_line_n(irq_line_n), .power_valid_output(power_valid_output),
        .reg_enable(reg_enable), .gpo_out(gpo_out), .flags(flags),
        .reset_flag(reset_flag), .reset_mask(reset_mask), .soft_reset_bit(soft_reset_bit));

    pei_host_model pei_host_model_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .serve(serve), .irq_line_n(irq_line_n),
        .flags(flags), .reset_flag(reset_flag), .flag_clr(flag_clr),
        .reset_flag_clr(reset_flag_clr));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Let n edges pass, then sample once values have settled
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Host clears everything; line must go high again
    task automatic host_clear();
        @(posedge clk_sys) serve <= 1'b1;
        settle(8);
        chk(12'(irq_line_n), 12'h1);
        chk(flags, 12'h0);
        @(posedge clk_sys) serve <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_warn();
        @(posedge clk_sys) warn_in <= 2'b01;
        settle(5);
        chk(flags, 12'h010);
        chk(12'(irq_line_n), 12'h0);
        chk(12'(reg_enable), 12'hF);
        @(posedge clk_sys) warn_in <= 2'b00;
        host_clear();
    endtask

    // Masked flag latches but leaves the line released
    task automatic t_mask();
        @(posedge clk_sys) begin
            flag_mask <= 12'h020;
            warn_in   <= 2'b10;
        end
        settle(5);
        chk(flags, 12'h020);
        chk(12'(irq_line_n), 12'h1);
        @(posedge clk_sys) warn_in <= 2'b00;
        host_clear();
        @(posedge clk_sys) flag_mask <= 12'h000;
    endtask

    task automatic t_prot();
        @(posedge clk_sys) prot_in <= 4'h4;
        settle(5);
        chk(12'(reg_enable), 12'hB);
        chk(12'(gpo_out), 12'h3);
        chk(12'(irq_line_n), 12'h0);
        @(posedge clk_sys) prot_in <= 4'h0;
        host_clear();
        chk(12'(reg_enable), 12'hF);
    endtask

    task automatic t_pg();
        @(posedge clk_sys) pg_in <= 4'hF;
        settle(5);
        chk(flags, 12'h00F);
        chk(12'(power_valid_output), 12'h1);
        host_clear();
    endtask

    // Buck stays low past the filter count
    task automatic t_short();
        int i;
        @(posedge clk_sys) buck_low_in <= 2'b01;
        for (i = 0; i < SL + 40 && flags[10] !== 1'b1; i++) settle(1);
        if (i >= SL + 40) begin
            fail_count++;
            final_report();
        end
        chk(12'(i >= SL), 12'h1);
        settle(2);
        chk(12'(reg_enable), 12'hE);
        @(posedge clk_sys) buck_low_in <= 2'b00;
        host_clear();
        chk(12'(reg_enable), 12'hF);
    endtask

    task automatic t_fault();
        @(posedge clk_sys) begin
            pg_in          <= 4'h0;
            otp_reset_mask <= 1'b0;
        end
        host_clear();
        @(posedge clk_sys) fault_in <= 2'b10;
        settle(5);
        chk(12'(reg_enable), 12'h0);
        chk(12'(gpo_out), 12'h0);
        chk(12'(power_valid_output), 12'h0);
        @(posedge clk_sys) fault_in <= 2'b00;
        settle(8);
        chk(12'(reset_flag), 12'h1);
        chk(12'(reset_mask), 12'h0);
        chk(12'(irq_line_n), 12'h0);
        chk(12'(reg_enable), 12'hF);
        host_clear();
        chk(12'(reset_flag), 12'h0);
    endtask

    // Soft reset with the cause masked by the one-time bit
    task automatic t_soft();
        @(posedge clk_sys) begin
            otp_reset_mask <= 1'b1;
            warn_in        <= 2'b01;
        end
        settle(5);
        chk(12'(irq_line_n), 12'h0);
        @(posedge clk_sys) begin
            soft_reset_trigger <= 1'b1;
            warn_in            <= 2'b00; // Gone before restart, so no new warning latches
        end
        @(posedge clk_sys) soft_reset_trigger <= 1'b0;
        #1;
        chk(12'(soft_reset_bit), 12'h1);
        settle(1);
        chk(12'(soft_reset_bit), 12'h0);
        chk(12'(reg_enable), 12'h0);
        chk(12'(gpo_out), 12'h0);
        chk(flags, 12'h0);
        settle(5);
        chk(12'(reset_flag), 12'h0);
        chk(12'(reset_mask), 12'h1);
        chk(12'(reg_enable), 12'hF);
        chk(12'(irq_line_n), 12'h1);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        settle(4);
        chk(12'(irq_line_n), 12'h1);
        chk(12'(reset_flag), 12'h0);
        chk(12'(reset_mask), 12'h1);
        t_warn();
        t_mask();
        t_prot();
        t_pg();
        t_short();
        t_fault();
        t_soft();
        final_report();
    end
endmodule

/* verification/pei_host_model.sv */
// Host processor model that clears every pending flag by writing ones
module pei_host_model #(
    parameter int LATENCY = 2
) (
    input  wire logic                      clk_sys,
    input  wire logic                      arst_n,
    input  wire logic                      serve,
    input  wire logic                      irq_line_n,
    input  wire logic [pei_pkg::NFLAG-1:0] flags,
    input  wire logic                      reset_flag,
    output logic      [pei_pkg::NFLAG-1:0] flag_clr,
    output logic                           reset_flag_clr
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned wait_cnt;

    // ****************************************
    // Service of pending flags
    // ****************************************
    // Waits LATENCY cycles, then one write-one-to-clear pulse of all pending bits
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_clr       <= '0;
            reset_flag_clr <= 1'b0;
            wait_cnt       <= 0;
        end else if (flag_clr != '0 || reset_flag_clr) begin
            flag_clr       <= '0; // Strobe lasts one cycle only
            reset_flag_clr <= 1'b0;
            wait_cnt       <= 0;
        end else if (serve && (!irq_line_n || (|flags) || reset_flag)) begin
            if (wait_cnt >= LATENCY) begin
                flag_clr       <= flags;
                reset_flag_clr <= reset_flag;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule
